// ---- pkg/image1_params.svh ----
// offsets, field positions, reset values and masks of the image 1 block
// assumes byte addressing on the register bus, one aligned word per register
`ifndef IMAGE1_PARAMS_SVH
`define IMAGE1_PARAMS_SVH

// register byte offsets
`define IMG1_CTL_OFS       12'hf10
`define IMG1_AT_OFS        12'hf14
`define IMG1_STAT_OFS      12'hf18

// control register fields
`define IMG1_POST_EN_BIT   31
`define IMG1_SPACE_BIT     24
`define IMG1_PREFETCH_BIT  23
`define IMG1_CTL_MASK      32'h8180_0000
`define IMG1_CTL_RESET     32'h0000_0000

// address translation register fields
`define IMG1_BASE_HI       31
`define IMG1_BASE_LO       16
`define IMG1_CODE_HI       7
`define IMG1_CODE_LO       4
`define IMG1_EN_BIT        0
`define IMG1_AT_MASK       32'hffff_00f1
`define IMG1_AT_RESET      32'h0000_0000

// smallest translated window is 64 Kbytes: bits 31..16
`define IMG1_XLAT_BASE_MASK 32'hffff_0000

`endif

// ---- pkg/image1_pkg.sv ----
// types shared by the image 1 decode and translate block
// assumes nothing of its surroundings
package image1_pkg;

	typedef enum logic [2:0]
	{
		cmd_delayed_read,
		cmd_prefetch_read,
		cmd_delayed_write,
		cmd_posted_write,
		cmd_bus_error
	} pci_cmd_type;

	typedef enum logic
	{
		st_idle,
		st_hold
	} lb_state_type;

	typedef struct packed
	{
		pci_cmd_type cmd;
		logic [31:0] addr;
	} pci_req_type;

endpackage

// ---- verilog/req_skid_buffer.sv ----
// two-entry buffer with valid and ready on both sides
// assumes one clock, synchronous active-high reset, clock enable freezes state
`timescale 1ns/10ps
module req_skid_buffer
#(
	parameter int WIDTH = 35
)
(
	input  wire logic             sys_clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);

	logic             out_valid_ff;
	logic [WIDTH-1:0] out_data_ff;
	logic             spare_valid_ff;
	logic [WIDTH-1:0] spare_data_ff;
	wire              push_w;
	wire              advance_w;

	assign push_w      = in_valid_i && !spare_valid_ff;
	assign advance_w   = !out_valid_ff || out_ready_i;
	assign in_ready_o  = !spare_valid_ff;
	assign out_valid_o = out_valid_ff;
	assign out_data_o  = out_data_ff;

	// a word arriving while the head is stalled parks in the spare slot
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			out_valid_ff   <= 1'b0;
			spare_valid_ff <= 1'b0;
			out_data_ff    <= '0;
			spare_data_ff  <= '0;
		end
		else if (ce_i)
		begin
			if (advance_w)
			begin
				out_valid_ff   <= spare_valid_ff || push_w;
				out_data_ff    <= spare_valid_ff ? spare_data_ff : in_data_i;
				spare_valid_ff <= 1'b0;
			end
			else if (push_w)
			begin
				spare_data_ff  <= in_data_i;
				spare_valid_ff <= 1'b1;
			end
		end
	end

endmodule

// ---- verilog/slave_image1_decode_translate.sv ----
// decode and address translation for the second local-bus slave image
// assumes local bus inputs synchronous to sys_clk_i and an Avalon-MM master
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/10ps
`include "image1_params.svh"

// What this block does
// - select plus image select one picks image
// - single read prefetches only if enabled and memory
// - burst read to I/O gives bus error
// - single write posts only if enabled and memory
// - burst write posts to memory, errors to I/O
// - translation base replaces translated upper address bits
// - translate only while translation-on bit set
// - block size code sets translated line count
// - translation fields read/write, cleared by reset
// - settings never loaded from serial memory
// - space select: 0 memory, 1 I/O, resets 0
// - post and prefetch enables, 1 on, reset 0
module slave_image1_decode_translate
	import image1_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic [11:0] avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        pci_window_select_n_i,
	input  wire logic        image_select_i,
	input  wire logic        lb_write_i,
	input  wire logic        lb_burst_i,
	input  wire logic [31:0] lb_addr_i,
	output logic             lb_ack_o,
	output logic             lb_berr_o,
	output logic             pci_req_valid_o,
	output pci_req_type      pci_req_o,
	input  wire logic        pci_req_ready_i
);

	// ==========================================================
	// register storage
	// ==========================================================
	logic [31:0]  ctl_ff;
	logic [31:0]  at_ff;
	logic [31:0]  readdata_ff;
	logic         waitrequest_ff;
	lb_state_type state_ff;
	lb_state_type nxt_state;
	logic         ack_ff;
	logic         berr_ff;
	pci_cmd_type  last_cmd_ff;
	logic         nxt_ack;
	logic         nxt_berr;

	// ==========================================================
	// register bus decode
	// ==========================================================
	wire [31:0] be_mask_w;
	wire        hit_ctl_w;
	wire        hit_at_w;
	wire        hit_stat_w;
	wire        wr_now_w;
	wire        rd_start_w;
	wire [31:0] rd_mux_w;
	wire [31:0] stat_w;
	wire        buf_in_ready_w;

	assign be_mask_w  = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
	                     {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	assign hit_ctl_w  = avs_address_i[11:2] == `IMG1_CTL_OFS >> 2;
	assign hit_at_w   = avs_address_i[11:2] == `IMG1_AT_OFS >> 2;
	assign hit_stat_w = avs_address_i[11:2] == `IMG1_STAT_OFS >> 2;
	// a write takes effect only at the edge where waitrequest is seen low
	assign wr_now_w   = avs_write_i && !waitrequest_ff;
	assign rd_start_w = (avs_read_i || avs_write_i) && waitrequest_ff;

	assign stat_w     = {27'h000_0000, !buf_in_ready_w, state_ff == st_hold, last_cmd_ff};

	// unmapped addresses read as zero, writes to them are dropped
	assign rd_mux_w   = hit_ctl_w  ? ctl_ff :
	                    hit_at_w   ? at_ff :
	                    hit_stat_w ? stat_w : 32'h0000_0000;

	wire [31:0] nxt_ctl_w;
	wire [31:0] nxt_at_w;

	assign nxt_ctl_w = ((ctl_ff & ~be_mask_w) | (avs_writedata_i & be_mask_w)) & `IMG1_CTL_MASK;
	assign nxt_at_w  = ((at_ff & ~be_mask_w) | (avs_writedata_i & be_mask_w)) & `IMG1_AT_MASK;

	// reset clears everything; no serial-memory preload path exists for this image
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			ctl_ff <= `IMG1_CTL_RESET;
			at_ff  <= `IMG1_AT_RESET;
		end
		else if (ce_i && wr_now_w)
		begin
			if (hit_ctl_w)
			begin
				ctl_ff <= nxt_ctl_w;
			end
			if (hit_at_w)
			begin
				at_ff <= nxt_at_w;
			end
		end
	end

	// waitrequest drops one cycle after a request is seen, then rises again
	// ce_i must stay high across the answer cycle: the master releases on the low waitrequest
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			waitrequest_ff <= 1'b1;
			readdata_ff    <= 32'h0000_0000;
		end
		else if (ce_i)
		begin
			waitrequest_ff <= !rd_start_w;
			if (rd_start_w)
			begin
				readdata_ff <= rd_mux_w;
			end
		end
	end

	assign avs_readdata_o    = readdata_ff;
	assign avs_waitrequest_o = waitrequest_ff;

	// ==========================================================
	// field extraction
	// ==========================================================
	wire        post_en_w;
	wire        io_space_w;
	wire        prefetch_en_w;
	wire [15:0] xlat_base_w;
	wire [3:0]  blk_code_w;
	wire        xlat_en_w;

	assign post_en_w     = ctl_ff[`IMG1_POST_EN_BIT];
	assign io_space_w    = ctl_ff[`IMG1_SPACE_BIT];
	assign prefetch_en_w = ctl_ff[`IMG1_PREFETCH_BIT];
	assign xlat_base_w   = at_ff[`IMG1_BASE_HI:`IMG1_BASE_LO];
	assign blk_code_w    = at_ff[`IMG1_CODE_HI:`IMG1_CODE_LO];
	assign xlat_en_w     = at_ff[`IMG1_EN_BIT];

	// ==========================================================
	// transaction decode
	// ==========================================================
	wire         sel_w;
	pci_cmd_type single_rd_w;
	pci_cmd_type burst_rd_w;
	pci_cmd_type single_wr_w;
	pci_cmd_type burst_wr_w;
	pci_cmd_type cmd_w;
	wire         err_w;

	assign sel_w       = !pci_window_select_n_i && image_select_i;
	assign single_rd_w = (prefetch_en_w && !io_space_w) ? cmd_prefetch_read : cmd_delayed_read;
	assign burst_rd_w  = io_space_w ? cmd_bus_error : cmd_delayed_read;
	assign single_wr_w = (post_en_w && !io_space_w) ? cmd_posted_write : cmd_delayed_write;
	assign burst_wr_w  = io_space_w ? cmd_bus_error : cmd_posted_write;
	assign cmd_w       = lb_write_i ? (lb_burst_i ? burst_wr_w : single_wr_w)
	                                : (lb_burst_i ? burst_rd_w : single_rd_w);
	assign err_w       = cmd_w == cmd_bus_error;

	// ==========================================================
	// address translation
	// ==========================================================
	wire [31:0] xlat_mask_w;
	wire [31:0] pci_addr_w;

	// translated lines run from A31 down to bit 16 plus the block size code
	assign xlat_mask_w = `IMG1_XLAT_BASE_MASK << blk_code_w;
	assign pci_addr_w  = xlat_en_w
	                   ? ((lb_addr_i & ~xlat_mask_w) | ({xlat_base_w, 16'h0000} & xlat_mask_w))
	                   : lb_addr_i;

	// ==========================================================
	// local bus handshake
	// ==========================================================
	wire         take_w;
	wire         push_w;
	pci_req_type req_in_w;

	// an error needs no buffer room, since it never reaches the PCI side
	// a full buffer stalls the access: the master keeps its select until the answer
	assign take_w   = (state_ff == st_idle) && sel_w && (err_w || buf_in_ready_w);
	assign push_w   = take_w && !err_w;
	assign req_in_w = '{cmd: cmd_w, addr: pci_addr_w};

	always_comb
	begin
		nxt_state = state_ff;
		nxt_ack   = 1'b0;
		nxt_berr  = 1'b0;
		case (state_ff)
			st_idle:
			begin
				if (take_w)
				begin
					nxt_state = st_hold;
					nxt_ack   = !err_w;
					nxt_berr  = err_w;
				end
			end
			st_hold:
			begin
				// the master must drop its select before the next access
				if (!sel_w)
				begin
					nxt_state = st_idle;
				end
			end
			default:
			begin
				nxt_state = st_idle;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			state_ff    <= st_idle;
			ack_ff      <= 1'b0;
			berr_ff     <= 1'b0;
			last_cmd_ff <= cmd_delayed_read;
		end
		else if (ce_i)
		begin
			state_ff <= nxt_state;
			ack_ff   <= nxt_ack;
			berr_ff  <= nxt_berr;
			if (take_w)
			begin
				last_cmd_ff <= cmd_w;
			end
		end
	end

	assign lb_ack_o  = ack_ff;
	assign lb_berr_o = berr_ff;

	// ==========================================================
	// request buffer toward the PCI master
	// ==========================================================
	logic [$bits(pci_req_type)-1:0] buf_out_w;

	req_skid_buffer
	#(
		.WIDTH ($bits(pci_req_type))
	)
	u_req_buffer
	(
		.sys_clk_i   (sys_clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.in_valid_i  (push_w),
		.in_ready_o  (buf_in_ready_w),
		.in_data_i   (req_in_w),
		.out_valid_o (pci_req_valid_o),
		.out_ready_i (pci_req_ready_i),
		.out_data_o  (buf_out_w)
	);

	assign pci_req_o = pci_req_type'(buf_out_w);

	// ==========================================================
	// checks
	// ==========================================================
	a_image_select_only: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		((lb_ack_o || lb_berr_o) && $past(ce_i))
		|-> (!$past(pci_window_select_n_i) && $past(image_select_i)))
		else $error("access answered without image 1 selected");

	a_single_read_kind: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		(take_w && !lb_write_i && !lb_burst_i)
		|-> ((cmd_w == cmd_prefetch_read) == (prefetch_en_w && !io_space_w)) && !err_w)
		else $error("single read decoded wrongly");

	a_burst_read_kind: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		(take_w && !lb_write_i && lb_burst_i)
		|-> (io_space_w ? cmd_w == cmd_bus_error : cmd_w == cmd_delayed_read))
		else $error("burst read decoded wrongly");

	a_single_write_kind: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		(take_w && lb_write_i && !lb_burst_i)
		|-> ((cmd_w == cmd_posted_write) == (post_en_w && !io_space_w)) && !err_w)
		else $error("single write decoded wrongly");

	a_burst_write_kind: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		(take_w && lb_write_i && lb_burst_i)
		|-> (io_space_w ? cmd_w == cmd_bus_error : cmd_w == cmd_posted_write))
		else $error("burst write decoded wrongly");

	a_top_code_xlat: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		(take_w && xlat_en_w && blk_code_w == 4'hf)
		|-> (pci_addr_w == {xlat_base_w[15], lb_addr_i[30:0]}))
		else $error("code 1111 must translate A31 only");

	a_base_xlat_bits: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		(take_w && xlat_en_w && blk_code_w == 4'h0)
		|-> (pci_addr_w == {xlat_base_w, lb_addr_i[15:0]}))
		else $error("code 0000 must translate A31 to A16");

	a_xlat_off_pass: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		(take_w && !xlat_en_w) |-> (pci_addr_w == lb_addr_i))
		else $error("address changed with translation off");

	a_berr_no_pci: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && take_w && err_w)
		|=> (lb_berr_o && !lb_ack_o && !$rose(pci_req_valid_o) && !$fell(buf_in_ready_w)))
		else $error("bus error reached the PCI side");

	a_regs_cleared: assert property (
		@(posedge sys_clk_i)
		$fell(rst_i) |-> (at_ff == 32'h0000_0000 && ctl_ff == 32'h0000_0000))
		else $error("settings not cleared by reset");

	a_bus_answer_one: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o)
		else $error("read not answered in one cycle");

endmodule

// ---- verification/pci_sink_model.sv ----
// far-side consumer of the image 1 request words
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module pci_sink_model
(
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic hold_i,
	output logic      pci_req_ready_o
);
	logic [7:0] lfsr_ff;

	// =========================================
	// ready pattern: stalls about a quarter of the time, always while held
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			lfsr_ff         <= 8'h5a;
			pci_req_ready_o <= 1'h0;
		end
		else
		begin
			lfsr_ff         <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
			pci_req_ready_o <= !hold_i && (lfsr_ff[0] || lfsr_ff[2]);
		end
	end
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench of the image 1 decode and translate block
// assumes the design files and the sink model are compiled first
`timescale 1ns/10ps
`include "image1_params.svh"
module tb_top
	import image1_pkg::*;
;
	logic        sys_clk_i = 1'h0;
	logic        rst_i     = 1'h1;
	logic [11:0] av_addr   = 12'h000;
	logic        av_rd     = 1'h0;
	logic        av_wr     = 1'h0;
	logic [31:0] av_wdata  = 32'h0000_0000;
	logic [31:0] av_rdata;
	logic        av_wait;
	logic        sel_n     = 1'h1;
	logic        img_sel   = 1'h0;
	logic        lb_wr     = 1'h0;
	logic        lb_bst    = 1'h0;
	logic [31:0] lb_a      = 32'h0000_0000;
	logic        ack;
	logic        berr;
	logic        req_valid;
	pci_req_type req;
	logic        req_ready;
	logic        hold      = 1'h0;
	int          errors    = 0;
	int          check_count = 0;
	int          seed      = 79836;
	int          n;
	logic [31:0] ctl_m     = 32'h0000_0000;
	logic [31:0] at_m      = 32'h0000_0000;
	logic [31:0] d;
	pci_req_type exp_q[$];
	pci_req_type e_mon;

	slave_image1_decode_translate i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'h1),
		.avs_address_i(av_addr), .avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wdata),
		.avs_byteenable_i(4'hf), .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait),
		.pci_window_select_n_i(sel_n), .image_select_i(img_sel), .lb_write_i(lb_wr), .lb_burst_i(lb_bst),
		.lb_addr_i(lb_a), .lb_ack_o(ack), .lb_berr_o(berr), .pci_req_valid_o(req_valid), .pci_req_o(req),
		.pci_req_ready_i(req_ready));

	pci_sink_model i_sink (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .hold_i(hold), .pci_req_ready_o(req_ready));

	initial
	begin
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	// =========================================
	// checking and closing
	task chk(input logic [34:0] s, input logic [34:0] e);
		check_count++;
		if (s !== e)
		begin
			errors++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask

	task results;
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	function pci_cmd_type f_cmd(input logic w, input logic b);
		logic pw;
		logic ps;
		logic pr;
		pw = ctl_m[`IMG1_POST_EN_BIT];
		ps = ctl_m[`IMG1_SPACE_BIT];
		pr = ctl_m[`IMG1_PREFETCH_BIT];
		if (!w)
			return b ? (ps ? cmd_bus_error : cmd_delayed_read) : ((pr && !ps) ? cmd_prefetch_read : cmd_delayed_read);
		return b ? (ps ? cmd_bus_error : cmd_posted_write) : ((pw && !ps) ? cmd_posted_write : cmd_delayed_write);
	endfunction

	function logic [31:0] f_addr(input logic [31:0] a);
		logic [31:0] m;
		m = 32'hffff_ffff << (16 + at_m[7:4]);
		return at_m[0] ? ((at_m & m) | (a & ~m)) : a;
	endfunction

	// =========================================
	// register bus master
	task av(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] ex);
		int k;
		av_addr  <= a;
		av_wr    <= w;
		av_rd    <= !w;
		av_wdata <= wd;
		k = 0;
		@(posedge sys_clk_i);
		while (av_wait !== 1'h0 && k < 50)
		begin
			k++;
			@(posedge sys_clk_i);
		end
		if (k == 50)
		begin
			errors++;
			results();
		end
		if (!w)
			chk(av_rdata, ex);
		if (w && a == `IMG1_CTL_OFS)
			ctl_m = wd & `IMG1_CTL_MASK;
		if (w && a == `IMG1_AT_OFS)
			at_m = wd & `IMG1_AT_MASK;
		av_wr <= 1'h0;
		av_rd <= 1'h0;
		@(posedge sys_clk_i);
	endtask

	// =========================================
	// local bus access; expectation noted before driving
	task lb(input logic w, input logic b, input logic s, input logic [31:0] a, input int lim, output int k);
		pci_cmd_type c;
		logic        hit;
		logic        be;
		c = f_cmd(w, b);
		if (s && c != cmd_bus_error)
			exp_q.push_back({c, f_addr(a)});
		sel_n   <= 1'h0;
		img_sel <= s;
		lb_wr   <= w;
		lb_bst  <= b;
		lb_a    <= a;
		hit = 1'h0;
		be  = 1'h0;
		k   = 0;
		while (!hit && k < lim)
		begin
			@(posedge sys_clk_i);
			k++;
			hit = (ack === 1'h1) || (berr === 1'h1);
			be  = (berr === 1'h1);
		end
		if (s && !hit)
		begin
			errors++;
			results();
		end
		chk({hit, be}, {s, s && c == cmd_bus_error});
		sel_n <= 1'h1;
		@(posedge sys_clk_i);
	endtask

	task wt_idle;
		int k;
		k = 0;
		while (req_valid !== 1'h0 && k < 100)
		begin
			k++;
			@(posedge sys_clk_i);
		end
		if (k == 100)
		begin
			errors++;
			results();
		end
	endtask

	// =========================================
	// monitor: each request word taken by the sink against the oldest note
	always @(posedge sys_clk_i)
	begin
		if (rst_i === 1'h0 && req_valid === 1'h1 && req_ready === 1'h1)
		begin
			e_mon = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
			chk(req, e_mon);
		end
	end

	// =========================================
	// main sequence
	initial
	begin
		repeat (5) @(posedge sys_clk_i);
		rst_i <= 1'h0;
		av(1'h0, `IMG1_CTL_OFS, 32'h0000_0000, 32'h0000_0000);
		av(1'h0, `IMG1_AT_OFS, 32'h0000_0000, 32'h0000_0000);
		av(1'h1, 12'h004, 32'hffff_ffff, 32'h0000_0000);
		av(1'h0, 12'h004, 32'h0000_0000, 32'h0000_0000);
		lb(1'h1, 1'h0, 1'h0, $random(seed), 4, n);
		for (int i = 0; i < 64; i++)
		begin
			if (i[1:0] == 2'h0)
			begin
				d = $random(seed);
				d[`IMG1_POST_EN_BIT] = i[4];
				d[`IMG1_SPACE_BIT] = i[3];
				d[`IMG1_PREFETCH_BIT] = i[2];
				av(1'h1, `IMG1_CTL_OFS, d, 32'h0000_0000);
				av(1'h0, `IMG1_CTL_OFS, 32'h0000_0000, ctl_m);
				d = $random(seed);
				d[`IMG1_EN_BIT] = i[5];
				d[`IMG1_CODE_HI:`IMG1_CODE_LO] = (i[3:2] == 2'h0) ? 4'h0
					: ((i[3:2] == 2'h3) ? 4'hf : d[`IMG1_CODE_HI:`IMG1_CODE_LO]);
				av(1'h1, `IMG1_AT_OFS, d, 32'h0000_0000);
				av(1'h0, `IMG1_AT_OFS, 32'h0000_0000, at_m);
			end
			lb(i[1], i[0], 1'h1, $random(seed), 40, n);
		end
		// buffer: two words held while the sink stalls, the third refused
		wt_idle();
		hold <= 1'h1;
		@(posedge sys_clk_i);
		lb(1'h1, 1'h0, 1'h1, $random(seed), 40, n);
		lb(1'h1, 1'h0, 1'h1, $random(seed), 40, n);
		fork
			begin
				repeat (6) @(posedge sys_clk_i);
				hold <= 1'h0;
			end
		join_none
		lb(1'h1, 1'h0, 1'h1, $random(seed), 40, n);
		chk(n > 5, 1'h1);
		wt_idle();
		chk(exp_q.size(), 0);
		av(1'h0, `IMG1_STAT_OFS, 32'h0000_0000, {29'h0000_0000, f_cmd(1'h1, 1'h0)});
		results();
	end
endmodule
